// file: logic/command_source_map.vh
`ifndef COMMAND_SOURCE_MAP_VH
`define COMMAND_SOURCE_MAP_VH
`define SRC_DIGITAL 2'h0
`define SRC_SERIAL 2'h1
`define SRC_AND 2'h2
`define SRC_OR 2'h3
`define SRC_RESET 2'h3
`define ADDR_START_SEL 12'h000
`define ADDR_REVERSE_SEL 12'h004
`define ADDR_SETUP_SEL 12'h008
`define ADDR_PRESET_SEL 12'h00C
`define ADDR_SERIAL_CMD 12'h010
`define ADDR_STATUS 12'h014
`define SER_START_BIT 0
`define SER_REVERSE_BIT 1
`define SER_SETUP_LSB 2
`define SER_PRESET_LSB 4
`endif

// file: logic/source_mix.v
`timescale 1ns/100ps
module source_mix #(
	parameter W = 1
) (
	input wire [1:0] sel,
	input wire [W-1:0] dig,
	input wire [W-1:0] ser,
	output reg [W-1:0] mix
);
`include "command_source_map.vh"
	// bitwise combine, so multi-bit codes follow the same four modes
	always @* begin
		case (sel)
			`SRC_DIGITAL: mix = dig;
			`SRC_SERIAL: mix = ser;
			`SRC_AND: mix = dig & ser;
			`SRC_OR: mix = dig | ser;
			default: mix = dig | ser;
		endcase
	end
endmodule

// file: logic/command_source_combiner.v
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
// How it works
// - each selector decodes 0 digital only, 1 serial only, 2 AND of both, 3 OR of both.
// - start is asserted only when the selected combination of start inputs is 1.
// - reverse (anti-clockwise) follows the selected combination of reversing inputs.
// - in modes 0 and 1 the 2-bit setup code is taken from digital or serial bits, 00..11 meaning setup 1..4.
// - in modes 2 and 3 the setup code is the bitwise AND or OR of bus and digital codes.
// - preset reference uses its own selector with the same four codes.
// - in serial-only mode a command comes only from the serial bit, whatever the digital level.
module command_source_combiner (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire din_start,
	input wire din_reverse,
	input wire [1:0] din_setup,
	input wire [1:0] din_preset,
	output reg start_q,
	output reg reverse_q,
	output reg [1:0] setup_q,
	output reg [1:0] preset_q
);
`include "command_source_map.vh"
	// six terminal bits: start, reverse, two setup, two preset
	localparam PIN_W = 6;

	reg [1:0] start_sel_q;
	reg [1:0] reverse_sel_q;
	reg [1:0] setup_sel_q;
	reg [1:0] preset_sel_q;
	reg [5:0] ser_cmd_q;
	reg [31:0] rdata_d;
	wire [PIN_W-1:0] din_all;
	wire [PIN_W-1:0] din_sync;
	wire start_d;
	wire reverse_d;
	wire [1:0] setup_d;
	wire [1:0] preset_d;
	wire setup_phase;
	wire access;
	wire in_range;
	wire aligned;
	wire mapped;
	wire wr_en;
	wire rd_load;
	wire hit_start_sel;
	wire hit_reverse_sel;
	wire hit_setup_sel;
	wire hit_preset_sel;
	wire hit_ser_cmd;

	assign din_all = {din_preset, din_setup, din_reverse, din_start};
	// terminals are asynchronous pins: two flops per bit before any logic reads them
	genvar b;
	generate
		for (b = 0; b < PIN_W; b = b + 1) begin : g_sync
			reg meta_q;
			reg stable_q;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_q <= 1'h0;
					stable_q <= 1'h0;
				end else begin
					meta_q <= din_all[b];
					stable_q <= meta_q;
				end
			end
			assign din_sync[b] = stable_q;
		end
	endgenerate

	// zero wait states: every access phase ends at its first edge
	assign pready = 1'h1;
	assign setup_phase = psel & ~penable;
	assign access = psel & penable;
	assign in_range = (paddr <= `ADDR_STATUS);
	assign aligned = (paddr[1:0] == 2'h0);
	assign mapped = in_range & aligned;
	// refused writes leave every register untouched; a refused read loads prdata with zero
	assign pslverr = access & ~mapped;
	assign wr_en = access & pwrite & mapped;
	// read data is latched in the setup phase, so it stands from a flop through the access phase
	assign rd_load = setup_phase & ~pwrite;
	assign hit_start_sel = (paddr == `ADDR_START_SEL);
	assign hit_reverse_sel = (paddr == `ADDR_REVERSE_SEL);
	assign hit_setup_sel = (paddr == `ADDR_SETUP_SEL);
	assign hit_preset_sel = (paddr == `ADDR_PRESET_SEL);
	assign hit_ser_cmd = (paddr == `ADDR_SERIAL_CMD);

	// a selector write keeps only the two low bits
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_sel_q <= `SRC_RESET;
		end else if (wr_en && hit_start_sel) begin
			start_sel_q <= pwdata[1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reverse_sel_q <= `SRC_RESET;
		end else if (wr_en && hit_reverse_sel) begin
			reverse_sel_q <= pwdata[1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_sel_q <= `SRC_RESET;
		end else if (wr_en && hit_setup_sel) begin
			setup_sel_q <= pwdata[1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preset_sel_q <= `SRC_RESET;
		end else if (wr_en && hit_preset_sel) begin
			preset_sel_q <= pwdata[1:0];
		end
	end

	// stands in for the control bits latched from the serial link
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_cmd_q <= 6'h00;
		end else if (wr_en && hit_ser_cmd) begin
			ser_cmd_q <= pwdata[5:0];
		end
	end

	// status is read-only; a write to it completes without effect
	always @* begin
		case (paddr)
			`ADDR_START_SEL: rdata_d = {30'h0, start_sel_q};
			`ADDR_REVERSE_SEL: rdata_d = {30'h0, reverse_sel_q};
			`ADDR_SETUP_SEL: rdata_d = {30'h0, setup_sel_q};
			`ADDR_PRESET_SEL: rdata_d = {30'h0, preset_sel_q};
			`ADDR_SERIAL_CMD: rdata_d = {26'h0, ser_cmd_q};
			`ADDR_STATUS: rdata_d = {26'h0, preset_q, setup_q, reverse_q, start_q};
			default: rdata_d = 32'h0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd_load) begin
			prdata <= rdata_d;
		end
	end

	// outputs are flops so the drive never sees decode glitches
	// start: high runs the motor, low stops it
	source_mix #(.W(1)) u_start (
		.sel(start_sel_q),
		.dig(din_sync[0]),
		.ser(ser_cmd_q[`SER_START_BIT]),
		.mix(start_d)
	);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q <= 1'h0;
		end else begin
			start_q <= start_d;
		end
	end

	// reverse: high is anti-clockwise, low clockwise
	source_mix #(.W(1)) u_reverse (
		.sel(reverse_sel_q),
		.dig(din_sync[1]),
		.ser(ser_cmd_q[`SER_REVERSE_BIT]),
		.mix(reverse_d)
	);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reverse_q <= 1'h0;
		end else begin
			reverse_q <= reverse_d;
		end
	end

	// setup code 0..3 names active setup 1..4
	source_mix #(.W(2)) u_setup (
		.sel(setup_sel_q),
		.dig(din_sync[3:2]),
		.ser(ser_cmd_q[`SER_SETUP_LSB+1:`SER_SETUP_LSB]),
		.mix(setup_d)
	);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_q <= 2'h0;
		end else begin
			setup_q <= setup_d;
		end
	end

	// preset reference code, combined bitwise like setup
	source_mix #(.W(2)) u_preset (
		.sel(preset_sel_q),
		.dig(din_sync[5:4]),
		.ser(ser_cmd_q[`SER_PRESET_LSB+1:`SER_PRESET_LSB]),
		.mix(preset_d)
	);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preset_q <= 2'h0;
		end else begin
			preset_q <= preset_d;
		end
	end
endmodule

// file: verification/command_source_combiner_assertions.sv
`timescale 1ns/100ps
module command_source_combiner_assertions (
	input wire pclk, presetn, psel, penable, pwrite, pready, pslverr, din_start, start_q, reverse_q,
	input wire [11:0] paddr,
	input wire [31:0] pwdata, prdata,
	input wire [1:0] din_preset, setup_q, preset_q
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire bad = paddr > 12'h014 || paddr[1:0] != 2'h0;
	wire [5:0] outs = {preset_q, setup_q, reverse_q, start_q};
	a_ready_high: assert property (pready) else $error("pready low");
	a_bad_refused: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0)) else $error("bad access");
	a_good_taken: assert property (acc && !bad |-> !pslverr) else $error("good access refused");
	a_status_view: assert property (acc && !pwrite && paddr == 12'h014 |-> prdata == {26'h0, $past(outs)})
		else $error("status mismatch");
	a_reset_idle: assert property ($rose(presetn) |-> outs == 6'h00) else $error("outputs not idle");
	// only start gets a hold check, and only start and preset get digital-mode checks: all four paths share one mix module
	a_start_hold: assert property ((!psel && $stable(din_start))[*4] |=> $stable(start_q))
		else $error("start moved");
	a_start_dig: assert property (acc && pwrite && paddr == 12'h000 && pwdata[1:0] == 2'h0
		##1 ($stable(din_start) && !(psel && paddr == 12'h000))[*4] |-> start_q == din_start) else $error("start");
	a_preset_dig: assert property (acc && pwrite && paddr == 12'h00C && pwdata[1:0] == 2'h0
		##1 ($stable(din_preset) && !(psel && paddr == 12'h00C))[*4] |-> preset_q == din_preset) else $error("preset");
endmodule

// file: verification/terminal_model.sv
`timescale 1ns/100ps
module terminal_model (
	input wire pclk,
	input wire [5:0] lvl,
	output reg din_start,
	output reg din_reverse,
	output reg [1:0] din_setup,
	output reg [1:0] din_preset
);
	// levels move just after an edge, so the sync sees clean steps
	always @(posedge pclk) {din_preset, din_setup, din_reverse, din_start} <= lvl;
endmodule

// file: verification/command_source_combiner_test.sv
`timescale 1ns/100ps
module command_source_combiner_test;
	reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0, rd;
	reg [5:0] lvl = 6'h00, e;
	wire [31:0] prdata;
	wire pready, pslverr, din_start, din_reverse, start_q, reverse_q;
	wire [1:0] din_setup, din_preset, setup_q, preset_q;
	integer seed = 43, num_errors = 0, n_checks = 0, cyc = 0, i, j, r;
	command_source_combiner DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .din_start, .din_reverse, .din_setup, .din_preset, .start_q, .reverse_q, .setup_q, .preset_q);
	terminal_model far (.pclk, .lvl, .din_start, .din_reverse, .din_setup, .din_preset);
	initial forever #5 pclk = ~pclk;
	function [1:0] mx(input [1:0] m, d, s);
		case (m)
			2'h0: mx = d;
			2'h1: mx = s;
			2'h2: mx = d & s;
			default: mx = d | s;
		endcase
	endfunction
	task ck(input [31:0] g, x);
		n_checks = n_checks + 1;
		if (g !== x) begin
			num_errors = num_errors + 1;
			$display("ERROR %0t got %h exp %h", $time, g, x);
		end
	endtask
	task apb(input [11:0] a, input w, input [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 6; i = i + 1) begin
			apb(12'h004 * i, 1'b0, 32'h0);
			ck(rd, i < 4 ? 32'h3 : 32'h0);
		end
		apb(12'h018, 1'b0, 32'h0);
		ck({rd[30:0], er}, 32'h1);
		apb(12'h001, 1'b1, 32'h0);
		ck(er, 32'h1);
		apb(12'h000, 1'b0, 32'h0);
		ck({rd[30:0], er}, 32'h6);
		for (i = 0; i < 40; i = i + 1) begin
			r = $random(seed);
			lvl <= r[19:14];
			apb(12'h010, 1'b1, r[13:8]);
			for (j = 0; j < 4; j = j + 1) apb(12'h004 * j, 1'b1, r[j*2+:2]);
			repeat (6) @(posedge pclk);
			e = mx(r[7:6], r[19:18], r[13:12]) << 4 | mx(r[5:4], r[17:16], r[11:10]) << 2
				| mx(r[3:2], r[15], r[9]) << 1 | mx(r[1:0], r[14], r[8]);
			apb(12'h014, 1'b0, 32'h0);
			ck(rd, e);
			ck({preset_q, setup_q, reverse_q, start_q}, e);
		end
		wrap_up;
	end
endmodule
bind command_source_combiner command_source_combiner_assertions chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.pready, .pslverr, .din_start, .start_q, .reverse_q, .paddr, .pwdata, .prdata, .din_preset, .setup_q, .preset_q);
